// >>> design/irao_pkg.sv
// Purpose: shared constants and types for the inertial output registers
// Assumes: 16-bit register words at even byte addresses
// Notes:   rate axes occupy sample slots 0..2, acceleration 3..4
package irao_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_AXES = 5;
    localparam int NUM_RATE = 3;
    localparam int AX_RATE_X = 0;
    localparam int AX_RATE_Y = 1;
    localparam int AX_RATE_Z = 2;
    localparam int AX_ACCEL_X = 3;
    localparam int AX_ACCEL_Y = 4;

    // ----------------------------------------------------------------
    // Register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_X_RATE_FRAC = 7'h04;
    localparam logic [6:0] ADDR_X_RATE_INT = 7'h06;
    localparam logic [6:0] ADDR_Y_RATE_FRAC = 7'h08;
    localparam logic [6:0] ADDR_Y_RATE_INT = 7'h0a;
    localparam logic [6:0] ADDR_Z_RATE_FRAC = 7'h0c;
    localparam logic [6:0] ADDR_Z_RATE_INT = 7'h0e;
    localparam logic [6:0] ADDR_X_ACCEL_FRAC = 7'h10;
    localparam logic [6:0] ADDR_X_ACCEL_INT = 7'h12;
    localparam logic [6:0] ADDR_Y_ACCEL_FRAC = 7'h14;
    localparam logic [6:0] ADDR_Y_ACCEL_INT = 7'h16;
    localparam logic [6:0] ADDR_FIRST = ADDR_X_RATE_FRAC;
    localparam logic [6:0] ADDR_LAST = ADDR_Y_ACCEL_INT;

    // ----------------------------------------------------------------
    // Codes and scales
    // ----------------------------------------------------------------
    localparam logic [15:0] RATE_FS_CODE = 16'h4e20;
    localparam logic [15:0] ACCEL_FS_CODE = 16'h7d00;
    localparam logic [15:0] ZERO_CODE = 16'h0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // Rate scale per integer count, micro-degrees per second
    localparam logic [31:0] RATE_SCALE_125 = 32'h0000_186a;
    localparam logic [31:0] RATE_SCALE_500 = 32'h0000_61a8;
    localparam logic [31:0] RATE_SCALE_2000 = 32'h0001_86a0;
    // Acceleration per integer count, micrometres per second squared
    localparam logic [31:0] ACCEL_LSB_UM = 32'h0000_0992;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        IRAO_RANGE_125 = 2'b00,
        IRAO_RANGE_500 = 2'b01,
        IRAO_RANGE_2000 = 2'b10
    } irao_range_t;

    typedef enum logic {
        IRAO_EMPTY = 1'b0,
        IRAO_LIVE = 1'b1
    } irao_fill_t;

    typedef logic [NUM_AXES-1:0][31:0] irao_sample_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [6:0] addr;
    } irao_req_t;

    typedef struct packed {
        irao_fill_t fill;
        irao_sample_t data;
        logic [15:0] rdData;
        logic rdValid;
        logic [31:0] rateScale;
    } irao_state_t;

endpackage

// >>> design/irao_clamp.sv
// Purpose: saturate one 32-bit axis value to its full-scale code
// Assumes: full scale falls on an integer count, fraction zero
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none

module irao_clamp #(
    parameter logic [15:0] FS_CODE = irao_pkg::RATE_FS_CODE
) (
    // Raw value in
    input wire logic [31:0] valueIn,
    // Limited value out
    output logic [31:0] valueOut
);

    logic signed [31:0] posLimit;
    logic signed [31:0] negLimit;

    // Negative limit is the exact negation, so the two ends stay symmetric
    assign posLimit = {FS_CODE, irao_pkg::ZERO_CODE};
    assign negLimit = -posLimit;

    always_comb
    begin
        if ($signed(valueIn) > posLimit)
        begin
            valueOut = posLimit;
        end
        else if ($signed(valueIn) < negLimit)
        begin
            valueOut = negLimit;
        end
        else
        begin
            valueOut = valueIn;
        end
    end

endmodule // irao_clamp

`default_nettype wire

// >>> design/irao_output_regs.sv
// Purpose: read-only rate and acceleration output register set
// Assumes: serial front end delivers one-cycle read/write strobes
// Notes:   one read answer per strobe, one cycle later
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Each rate axis reads as two words, high above low, one 32-bit value.
// - Rate high word is two's complement; zero rotation reads 0x0000.
// - Rate low word holds sixteen extra resolution bits.
// - Rate scale is 0.00625, 0.025 or 0.1 dps per count by range.
// - Rate full scale reads 0x4E20 and 0xB1E0 in the high word.
// - Each acceleration axis reads as high and low words, one 32-bit value.
// - Acceleration high word two's complement, 2.45 mm/s2 per count.
// - Acceleration full scale reads 0x7D00 and 0x8300 in the high word.
// - Acceleration low word holds sixteen extra resolution bits.
// - Rate words at 0x04..0x0E, low word first, read-only.
// - Acceleration words at 0x10..0x16, low word first, read-only.
// - All output words refresh together on each new sample.
module irao_output_regs #(
    parameter irao_pkg::irao_range_t RANGE = irao_pkg::IRAO_RANGE_125
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Processed sample from the pipeline
    input wire logic sampleValid,
    input wire irao_pkg::irao_sample_t sampleIn,
    // Register access from the serial front end
    input wire irao_pkg::irao_req_t req,
    output logic [15:0] rdData,
    output logic rdValid,
    // Status
    output logic dataLive,
    output logic [31:0] rateScale
);

    // ----------------------------------------------------------------
    // Input limiting
    // ----------------------------------------------------------------
    irao_pkg::irao_sample_t limited;

    genvar gi;
    generate
        for (gi = 0; gi < irao_pkg::NUM_AXES; gi++)
        begin : g_axis
            localparam logic [15:0] FS = (gi < irao_pkg::NUM_RATE) ?
                irao_pkg::RATE_FS_CODE : irao_pkg::ACCEL_FS_CODE;
            // Rate and acceleration saturate at their own codes
            // Signed limits keep zero at zero and the sign intact
            irao_clamp #(
                .FS_CODE(FS)
            ) u_clamp (
                .valueIn(sampleIn[gi]),
                .valueOut(limited[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic mapped;
    logic [6:0] offset;
    logic [2:0] axisSel;
    logic highSel;
    logic [31:0] axisWord;
    logic [31:0] scaleFor;
    irao_pkg::irao_state_t state_d;
    irao_pkg::irao_state_t state_q;

    always_comb
    begin
        mapped = (req.addr >= irao_pkg::ADDR_FIRST) &&
                 (req.addr <= irao_pkg::ADDR_LAST) && !req.addr[0];
        offset = 7'(req.addr - irao_pkg::ADDR_FIRST);
        // Two words per axis: bit 1 picks high, upper bits pick axis
        axisSel = offset[4:2];
        highSel = offset[1];
        axisWord = irao_pkg::ZERO_WORD;
        if (axisSel < 3'(irao_pkg::NUM_AXES))
        begin
            axisWord = state_q.data[axisSel];
        end
    end

    always_comb
    begin
        case (RANGE)
            irao_pkg::IRAO_RANGE_500: scaleFor = irao_pkg::RATE_SCALE_500;
            irao_pkg::IRAO_RANGE_2000: scaleFor = irao_pkg::RATE_SCALE_2000;
            default: scaleFor = irao_pkg::RATE_SCALE_125;
        endcase
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        state_d.rateScale = scaleFor;
        state_d.rdValid = req.rd;
        state_d.rdData = irao_pkg::ZERO_CODE;
        // Whole sample loads in one edge, so an axis never mixes samples
        if (sampleValid)
        begin
            state_d.data = limited;
        end
        case (state_q.fill)
            irao_pkg::IRAO_EMPTY:
            begin
                if (sampleValid)
                begin
                    state_d.fill = irao_pkg::IRAO_LIVE;
                end
            end
            irao_pkg::IRAO_LIVE:
            begin
                state_d.fill = irao_pkg::IRAO_LIVE;
            end
            default:
            begin
                state_d.fill = irao_pkg::IRAO_EMPTY;
            end
        endcase
        // Read returns the stored word; writes have no path into data
        if (req.rd && mapped)
        begin
            // High word above low word of one 32-bit value
            state_d.rdData = highSel ? axisWord[31:16] :
                                       axisWord[15:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q.fill <= irao_pkg::IRAO_EMPTY;
            state_q.data <= '0;
            state_q.rdData <= irao_pkg::ZERO_CODE;
            state_q.rdValid <= 1'b0;
            state_q.rateScale <= irao_pkg::ZERO_WORD;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign rdData = state_q.rdData;
    assign rdValid = state_q.rdValid;
    // Live code is 1, so the flag is the state bit itself
    assign dataLive = state_q.fill;
    assign rateScale = state_q.rateScale;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    property p_load_all;
        sampleValid |=> state_q.data == $past(limited);
    endproperty
    a_load_all: assert property (p_load_all)
        else $error("sample not loaded into all words");

    property p_hold;
        !sampleValid |=> $stable(state_q.data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output words changed without a sample");

    property p_rate_hi;
        req.rd && !sampleValid && req.addr == irao_pkg::ADDR_Y_RATE_INT
        |=> rdValid && rdData == state_q.data[irao_pkg::AX_RATE_Y][31:16];
    endproperty
    a_rate_hi: assert property (p_rate_hi)
        else $error("rate high word read wrong");

    property p_rate_lo;
        req.rd && !sampleValid && req.addr == irao_pkg::ADDR_Z_RATE_FRAC
        |=> rdData == state_q.data[irao_pkg::AX_RATE_Z][15:0];
    endproperty
    a_rate_lo: assert property (p_rate_lo)
        else $error("rate low word read wrong");

    property p_acc_hi;
        req.rd && !sampleValid && req.addr == irao_pkg::ADDR_X_ACCEL_INT
        |=> rdData == state_q.data[irao_pkg::AX_ACCEL_X][31:16];
    endproperty
    a_acc_hi: assert property (p_acc_hi)
        else $error("accel high word read wrong");

    property p_acc_lo;
        req.rd && !sampleValid && req.addr == irao_pkg::ADDR_Y_ACCEL_FRAC
        |=> rdData == state_q.data[irao_pkg::AX_ACCEL_Y][15:0];
    endproperty
    a_acc_lo: assert property (p_acc_lo)
        else $error("accel low word read wrong");

    property p_rate_fs;
        sampleValid && $signed(sampleIn[irao_pkg::AX_RATE_X]) >
            $signed({irao_pkg::RATE_FS_CODE, irao_pkg::ZERO_CODE})
        ##1 req.rd && !sampleValid && req.addr == irao_pkg::ADDR_X_RATE_INT
        |=> rdData == irao_pkg::RATE_FS_CODE;
    endproperty
    a_rate_fs: assert property (p_rate_fs)
        else $error("rate not saturated at full scale");

    property p_acc_fs;
        sampleValid && $signed(sampleIn[irao_pkg::AX_ACCEL_Y]) <
            -$signed({irao_pkg::ACCEL_FS_CODE, irao_pkg::ZERO_CODE})
        |=> state_q.data[irao_pkg::AX_ACCEL_Y][31:16] ==
            16'(-irao_pkg::ACCEL_FS_CODE);
    endproperty
    a_acc_fs: assert property (p_acc_fs)
        else $error("accel not saturated at negative full scale");

    property p_unmapped;
        req.rd && !mapped |=> rdValid && rdData == irao_pkg::ZERO_CODE;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_write_ignored;
        req.wr && !req.rd && !sampleValid
        |=> $stable(state_q.data) && !rdValid;
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("write disturbed output words");

    // Expected scale spelled out from the range, not from the decode above
    localparam logic [31:0] EXP_SCALE =
        (RANGE == irao_pkg::IRAO_RANGE_2000) ? irao_pkg::RATE_SCALE_2000 :
        (RANGE == irao_pkg::IRAO_RANGE_500) ? irao_pkg::RATE_SCALE_500 :
        irao_pkg::RATE_SCALE_125;

    property p_scale;
        1'b1 |=> rateScale == EXP_SCALE;
    endproperty
    a_scale: assert property (p_scale)
        else $error("rate scale does not match range");

    property p_rate_zero;
        sampleValid && sampleIn[irao_pkg::AX_RATE_Z] == irao_pkg::ZERO_WORD
        |=> state_q.data[irao_pkg::AX_RATE_Z] == irao_pkg::ZERO_WORD;
    endproperty
    a_rate_zero: assert property (p_rate_zero)
        else $error("zero rotation not read as zero");

    // Negative high words above the negative limit are inside the range
    localparam logic [15:0] ACC_NEG_FS = 16'(-irao_pkg::ACCEL_FS_CODE);

    property p_acc_pass;
        sampleValid && sampleIn[irao_pkg::AX_ACCEL_X][31] &&
            sampleIn[irao_pkg::AX_ACCEL_X][31:16] > ACC_NEG_FS
        |=> state_q.data[irao_pkg::AX_ACCEL_X] ==
            $past(sampleIn[irao_pkg::AX_ACCEL_X]);
    endproperty
    a_acc_pass: assert property (p_acc_pass)
        else $error("in-range acceleration altered");

    property p_rate_fs_neg;
        sampleValid && $signed(sampleIn[irao_pkg::AX_RATE_Z]) <
            -$signed({irao_pkg::RATE_FS_CODE, irao_pkg::ZERO_CODE})
        |=> state_q.data[irao_pkg::AX_RATE_Z] ==
            {16'(-irao_pkg::RATE_FS_CODE), irao_pkg::ZERO_CODE};
    endproperty
    a_rate_fs_neg: assert property (p_rate_fs_neg)
        else $error("rate not saturated at negative full scale");

    property p_acc_fs_pos;
        sampleValid && $signed(sampleIn[irao_pkg::AX_ACCEL_X]) >
            $signed({irao_pkg::ACCEL_FS_CODE, irao_pkg::ZERO_CODE})
        |=> state_q.data[irao_pkg::AX_ACCEL_X] ==
            {irao_pkg::ACCEL_FS_CODE, irao_pkg::ZERO_CODE};
    endproperty
    a_acc_fs_pos: assert property (p_acc_fs_pos)
        else $error("accel not saturated at positive full scale");

    property p_rd_valid;
        req.rd |=> rdValid;
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("read not answered");

    property p_rd_idle;
        !req.rd |=> !rdValid && rdData == irao_pkg::ZERO_CODE;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("answer present without a read");

    property p_live_stays;
        dataLive |=> dataLive;
    endproperty
    a_live_stays: assert property (p_live_stays)
        else $error("live flag dropped without reset");

    c_load: cover property (sampleValid ##1 dataLive);
    c_read_pair: cover property (
        req.rd && req.addr == irao_pkg::ADDR_X_RATE_FRAC
        ##[1:2] req.rd && req.addr == irao_pkg::ADDR_X_RATE_INT);
    c_sat: cover property (sampleValid && limited != sampleIn);
    c_write: cover property (req.wr && mapped);

endmodule // irao_output_regs

`default_nettype wire

// >>> tb/irao_host_model.sv
// Purpose: host side that reads and writes the output register set
// Assumes: every task is entered just after a falling clock edge
// Notes:   a strobe lasts one cycle and an idle cycle follows each access
`timescale 1ns/1ps
`default_nettype none

module irao_host_model (
    // Clock
    input wire logic clk,
    // Register access
    output var irao_pkg::irao_req_t req,
    input wire logic [15:0] rdData,
    input wire logic rdValid
);
    initial
    begin
        req = '0;
    end

    // The answer stands only in the cycle after the taking edge
    task automatic rdWord(input logic [6:0] addr, output logic [15:0] data,
        output logic ok);
        req.rd = 1'b1;
        req.addr = addr;
        @(posedge clk);
        @(negedge clk);
        ok = rdValid;
        data = rdData;
        req.rd = 1'b0;
        // Idle edge, so a following call never re-raises rd at once
        @(negedge clk);
    endtask

    task automatic wrWord(input logic [6:0] addr);
        req.wr = 1'b1;
        req.addr = addr;
        @(posedge clk);
        @(negedge clk);
        req.wr = 1'b0;
        @(negedge clk);
    endtask
endmodule // irao_host_model

`default_nettype wire

// >>> tb/irao_output_regs_tb_top.sv
// Purpose: self-checking bench for the inertial output register set
// Assumes: inputs change on the falling clock edge only
// Notes:   a second instance with the widest range checks its scale alone
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
    begin \
        checksDone++; \
        if ((got) !== (exp)) \
        begin \
            nFail++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end

module irao_output_regs_tb_top;
    logic clk;
    logic rst_b;
    logic sampleValid;
    irao_pkg::irao_sample_t sampleIn;
    irao_pkg::irao_req_t req;
    logic [15:0] rdData;
    logic rdValid;
    logic dataLive;
    logic [31:0] rateScale;
    logic [31:0] wideScale;
    logic [15:0] d;
    logic ok;
    int nFail;
    int checksDone;
    irao_pkg::irao_sample_t s1;
    irao_pkg::irao_sample_t s2;

    irao_output_regs i_dut (
        .clk(clk), .rst_b(rst_b), .sampleValid(sampleValid),
        .sampleIn(sampleIn), .req(req), .rdData(rdData),
        .rdValid(rdValid), .dataLive(dataLive), .rateScale(rateScale)
    );
    irao_output_regs #(.RANGE(irao_pkg::IRAO_RANGE_2000)) i_dut2 (
        .clk(clk), .rst_b(rst_b), .sampleValid(sampleValid),
        .sampleIn(sampleIn), .req(req), .rdData(), .rdValid(),
        .dataLive(), .rateScale(wideScale)
    );
    irao_host_model i_host (
        .clk(clk), .req(req), .rdData(rdData), .rdValid(rdValid)
    );

    always #10 clk = ~clk;

    task automatic results();
        $display("checks %0d mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic load(input irao_pkg::irao_sample_t s);
        sampleIn = s;
        sampleValid = 1'b1;
        @(negedge clk);
        sampleValid = 1'b0;
    endtask

    // Word i sits at 0x04 + 2i: low half of axis i/2, then high half
    task automatic chkAll(input irao_pkg::irao_sample_t e);
        for (int i = 0; i < 10; i++)
        begin
            i_host.rdWord(7'h04 + 7'(2 * i), d, ok);
            `CHK(ok, 1'b1)
            `CHK(d, e[i / 2][16 * (i % 2) +: 16])
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        nFail++;
        results();
    end

    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        sampleValid = 1'b0;
        sampleIn = '0;
        nFail = 0;
        checksDone = 0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        `CHK(rateScale, 32'h0000_186a)
        `CHK(wideScale, 32'h0001_86a0)
        `CHK(dataLive, 1'b0)
        chkAll('0);
        // Acceleration full scale both ways, rate positive full scale, zero, and a one-count negative fraction
        s1 = {32'h7d00_0000, 32'h8300_0000, 32'h0000_0000, 32'hffff_ffff,
            32'h4e20_0000};
        load(s1);
        `CHK(dataLive, 1'b1)
        chkAll(s1);
        // A read taken with a new sample still sees the old one
        s2 = {32'h0002_ffff, 32'hfffe_0001, 32'hb1e0_0000, 32'h0001_8000,
            32'h1234_5678};
        sampleIn = s2;
        sampleValid = 1'b1;
        fork
            i_host.rdWord(7'h06, d, ok);
            begin
                @(negedge clk);
                sampleValid = 1'b0;
            end
        join
        `CHK(d, 16'h4e20)
        `CHK(rdValid, 1'b0)
        `CHK(rdData, 16'h0000)
        i_host.wrWord(7'h06);
        i_host.wrWord(7'h14);
        chkAll(s2);
        // Out-of-range inputs land on the full-scale codes
        load({32'h8000_0000, 32'h7fff_ffff, 32'hb1df_ffff, 32'h4e20_0001,
            32'h8000_0000});
        chkAll({32'h8300_0000, 32'h7d00_0000, 32'hb1e0_0000, 32'h4e20_0000,
            32'hb1e0_0000});
        // Positive overflow read right after the load
        load({5{32'h7fff_ffff}});
        i_host.rdWord(7'h06, d, ok);
        `CHK(d, 16'h4e20)
        i_host.rdWord(7'h16, d, ok);
        `CHK(d, 16'h7d00)
        for (int i = 0; i < 3; i++)
        begin
            i_host.rdWord(i == 0 ? 7'h18 : (i == 1 ? 7'h07 : 7'h02), d, ok);
            `CHK(ok, 1'b1)
            `CHK(d, 16'h0000)
        end
        rst_b = 1'b0;
        @(negedge clk);
        rst_b = 1'b1;
        `CHK(dataLive, 1'b0)
        i_host.rdWord(7'h06, d, ok);
        `CHK(d, 16'h0000)
        `CHK(rateScale, 32'h0000_186a)
        results();
    end
endmodule // irao_output_regs_tb_top

`default_nettype wire
